// [common/tgs_consts.svh]
`ifndef TGS_CONSTS_SVH
`define TGS_CONSTS_SVH
// Register byte offsets
`define TGS_OFF_CTRL 8'h00
`define TGS_OFF_CYC_VAL 8'h04
`define TGS_OFF_CYC_UNIT 8'h08
`define TGS_OFF_CYC_EXT 8'h0C
`define TGS_OFF_BASE_SLO 8'h10
`define TGS_OFF_BASE_SHI 8'h14
`define TGS_OFF_BASE_NS 8'h18
`define TGS_OFF_ENT_CTRL 8'h1C
`define TGS_OFF_ENT_IVL 8'h20
`define TGS_OFF_LIST_LEN 8'h24
`define TGS_OFF_COMMIT 8'h28
`define TGS_OFF_TIMEOUT 8'h2C
`define TGS_OFF_SDU_BASE 8'h40
`define TGS_OFF_GUARD_BASE 8'h60
`define TGS_OFF_STAT 8'h80
`define TGS_OFF_ERR 8'h84
`define TGS_OFF_CHG_SLO 8'h88
`define TGS_OFF_CHG_SHI 8'h8C
`define TGS_OFF_CHG_NS 8'h90
`define TGS_OFF_TICK 8'h94
`define TGS_OFF_OPER_LEN 8'h98
`define TGS_OFF_OPER_VAL 8'h9C
`define TGS_OFF_OPER_UNIT 8'hA0
`define TGS_OFF_OPER_EXT 8'hA4
`define TGS_OFF_OPER_BSLO 8'hA8
`define TGS_OFF_OPER_BSHI 8'hAC
`define TGS_OFF_OPER_BNS 8'hB0
`define TGS_OFF_NOW_SLO 8'hB4
`define TGS_OFF_NOW_SHI 8'hB8
`define TGS_OFF_NOW_NS 8'hBC
// Values and limits
`define TGS_SDU_MAX 14'h2800
`define TGS_SDU_RST 14'h0600
`define TGS_FRAG_UNIT 14'h0040
`define TGS_FRAG_EXTRA 14'h0040
`define TGS_NS_PER_SEC 32'h3B9ACA00
`define TGS_NS_PER_US 64'h00000000000003E8
`define TGS_NS_PER_MS 64'h00000000000F4240
`define TGS_UNIT_MS 2'h0
`define TGS_UNIT_US 2'h1
`define TGS_UNIT_NS 2'h2
`define TGS_SPD_10M 2'h0
`define TGS_SPD_100M 2'h1
`define TGS_SPD_1G 2'h2
`define TGS_SPD_10G 2'h3
`define TGS_BIT_NS_10M 24'h000320
`define TGS_BIT_NS_100M 24'h000050
`define TGS_BITS_PER_BYTE 24'h000008
`define TGS_DIV_10G 24'h00000A
`define TGS_CLK_NS 32'h00000028
`define TGS_TICK_TENTHS (`TGS_CLK_NS * 32'h0000000A)
`define TGS_GATES_OPEN 8'hFF
`define TGS_LIST_DEPTH 4'h8
`endif

// [common/tgs_pkg.sv]
package tgs_pkg;
	typedef enum logic [2:0] {
		TGS_IDLE = 3'b001,
		TGS_SYNC = 3'b010,
		TGS_ARM = 3'b100
	} tgs_sched_e_t;
	typedef struct packed {
		logic [47:0] sec;
		logic [31:0] ns;
	} tgs_time_t;
	typedef struct packed {
		logic [7:0] gates;
		logic hold_gate_operation;
		logic [31:0] ivl;
	} tgs_entry_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} tgs_avm_req_t;
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} tgs_avm_rsp_t;
	typedef struct packed {
		logic [31:0] val;
		logic [1:0] unit;
		logic [31:0] ext;
		tgs_time_t base;
		logic [3:0] len;
	} tgs_sched_t;
	typedef struct packed {
		tgs_avm_rsp_t rsp;
		tgs_sched_e_t state;
		logic schedule_change_pending;
		logic adm_en;
		logic preempt_en;
		logic defer_en;
		logic [3:0] sync_sense_port;
		logic [7:0] pmask;
		logic [1:0] frag;
		logic [15:0] timeout;
		logic [15:0] defer_cnt;
		logic [7:0][13:0] sdu;
		logic [7:0][23:0] guard;
		tgs_entry_t [7:0] gate_list;
		logic [31:0] ivl_stage;
		tgs_sched_t adm;
		tgs_sched_t oper;
		logic [31:0] oper_cyc_ns;
		logic oper_en;
		tgs_time_t chg;
		tgs_time_t now;
		logic [31:0] err;
		logic [2:0] ent;
		logic [31:0] ent_el;
		logic [31:0] cyc_el;
		logic [7:0] gates;
		logic hold;
		logic [7:0] preempt;
	} tgs_st_t;
endpackage

// [verilog/tgs_scheduler.sv]
module tgs_scheduler (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire tgs_pkg::tgs_avm_req_t avm_in,
	output tgs_pkg::tgs_avm_rsp_t avm_out,
	input wire logic [47:0] ptp_sec_in,
	input wire logic [31:0] ptp_ns_in,
	input wire logic [15:0] ptp_locked_in,
	input wire logic [1:0] link_speed_in,
	output logic oper_enabled_out,
	output logic [7:0] gate_states_out,
	output logic hold_active_out,
	output logic [7:0] preemptible_out,
	output logic schedule_change_pending_out
);
`include "tgs_consts.svh"

	tgs_pkg::tgs_st_t st_q;
	tgs_pkg::tgs_st_t st_d;
	logic bus_acc;
	logic wr_acc;
	logic sec_tick;
	logic locked;

	////////////////////////////////////////////////////////////////
	function automatic logic t_ge(input tgs_pkg::tgs_time_t a, input tgs_pkg::tgs_time_t b);
		return {a.sec, a.ns} >= {b.sec, b.ns};
	endfunction

	// Delta must stay below one second; extension writes are clamped
	function automatic tgs_pkg::tgs_time_t t_add(input tgs_pkg::tgs_time_t t, input logic [31:0] d);
		logic [32:0] s;
		tgs_pkg::tgs_time_t r;
		s = {1'b0, t.ns} + {1'b0, d};
		r = t;
		if (s >= {1'b0, `TGS_NS_PER_SEC}) begin
			r.sec = t.sec + 48'h1;
			r.ns = 32'(s - {1'b0, `TGS_NS_PER_SEC});
		end else begin
			r.ns = s[31:0];
		end
		return r;
	endfunction

	// Past base time: start at next second keeping the base phase
	function automatic tgs_pkg::tgs_time_t chg_time(input tgs_pkg::tgs_time_t b, input tgs_pkg::tgs_time_t n);
		tgs_pkg::tgs_time_t r;
		r = b;
		if (!t_ge(b, n)) begin
			r.sec = n.sec + 48'h1;
		end
		return r;
	endfunction

	function automatic logic [31:0] cyc_ns(input logic [31:0] v, input logic [1:0] u);
		logic [63:0] p;
		unique case (u)
			`TGS_UNIT_MS: p = {32'h0, v} * `TGS_NS_PER_MS;
			`TGS_UNIT_US: p = {32'h0, v} * `TGS_NS_PER_US;
			default: p = {32'h0, v};
		endcase
		return (p[63:32] != 32'h0) ? 32'hFFFFFFFF : p[31:0];
	endfunction

	function automatic logic [13:0] sdu_eff(input logic [13:0] s);
		return (s == 14'h0) ? `TGS_SDU_MAX : s;
	endfunction

	function automatic logic [23:0] guard_ns(input logic [13:0] b, input logic [1:0] spd);
		logic [23:0] w;
		w = {10'h0, b};
		unique case (spd)
			`TGS_SPD_10M: return 24'(w * `TGS_BIT_NS_10M);
			`TGS_SPD_100M: return 24'(w * `TGS_BIT_NS_100M);
			`TGS_SPD_1G: return 24'(w * `TGS_BITS_PER_BYTE);
			default: return 24'((w * `TGS_BITS_PER_BYTE) / `TGS_DIV_10G);
		endcase
	endfunction

	function automatic logic is_arr(input logic [7:0] a, input logic [7:0] base);
		return (a[7:5] == base[7:5]) && (a[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////
	assign bus_acc = (avm_in.read | avm_in.write) & st_q.rsp.waitrequest;
	assign wr_acc = bus_acc & avm_in.write;
	assign sec_tick = (ptp_sec_in != st_q.now.sec);
	assign locked = ptp_locked_in[st_q.sync_sense_port];

	always_comb begin
		logic [31:0] nxt_cyc;
		logic [31:0] rd;
		logic [13:0] gb;
		tgs_pkg::tgs_time_t pb;
		nxt_cyc = st_q.cyc_el + `TGS_CLK_NS;
		rd = 32'h0;
		gb = 14'h0;
		pb = st_q.adm.base;
		st_d = st_q;
		st_d.now.sec = ptp_sec_in;
		st_d.now.ns = ptp_ns_in;

		// Gate list sequencing
		if (st_q.oper_en) begin
			if (nxt_cyc >= st_q.oper_cyc_ns) begin
				// Stretch the last entry only while the switch is within reach
				if (!((st_q.state == tgs_pkg::TGS_ARM) &&
						t_ge(t_add(st_q.now, st_q.oper.ext), st_q.chg))) begin
					st_d.ent = 3'h0;
					st_d.ent_el = 32'h0;
					st_d.cyc_el = 32'h0;
				end
			end else begin
				st_d.cyc_el = nxt_cyc;
				st_d.ent_el = st_q.ent_el + `TGS_CLK_NS;
				if ((st_d.ent_el >= st_q.gate_list[st_q.ent].ivl) &&
						({1'b0, st_q.ent} + 4'h1 < st_q.oper.len)) begin
					st_d.ent = st_q.ent + 3'h1;
					st_d.ent_el = 32'h0;
				end
			end
		end

		// Schedule change sequencing
		unique case (st_q.state)
			tgs_pkg::TGS_IDLE: begin
			end
			tgs_pkg::TGS_SYNC: begin
				if (sec_tick) begin
					st_d.defer_cnt = st_q.defer_cnt + 16'h1;
				end
				if (locked || (st_q.defer_cnt >= st_q.timeout)) begin
					st_d.state = tgs_pkg::TGS_ARM;
					st_d.chg = chg_time(st_q.adm.base, st_q.now);
				end
			end
			tgs_pkg::TGS_ARM: begin
				if (t_ge(st_q.now, st_q.chg)) begin
					st_d.state = tgs_pkg::TGS_IDLE;
					st_d.oper_en = st_q.adm_en;
					st_d.oper = st_q.adm;
					st_d.oper_cyc_ns = cyc_ns(st_q.adm.val, st_q.adm.unit);
					st_d.ent = 3'h0;
					st_d.ent_el = 32'h0;
					st_d.cyc_el = 32'h0;
				end
			end
		endcase

		// Register bus
		st_d.rsp.waitrequest = 1'b1;
		st_d.rsp.readdata = 32'h0;
		if (bus_acc) begin
			st_d.rsp.waitrequest = 1'b0;
		end
		if (wr_acc) begin
			unique case (avm_in.address)
				`TGS_OFF_CTRL: begin
					st_d.adm_en = avm_in.writedata[0];
					st_d.preempt_en = avm_in.writedata[1];
					st_d.defer_en = avm_in.writedata[2];
					st_d.sync_sense_port = avm_in.writedata[7:4];
					st_d.pmask = avm_in.writedata[15:8];
					st_d.frag = avm_in.writedata[17:16];
				end
				`TGS_OFF_CYC_VAL: st_d.adm.val = avm_in.writedata;
				`TGS_OFF_CYC_UNIT: st_d.adm.unit = (avm_in.writedata[1:0] > `TGS_UNIT_NS) ?
					`TGS_UNIT_NS : avm_in.writedata[1:0];
				`TGS_OFF_CYC_EXT: st_d.adm.ext = (avm_in.writedata >= `TGS_NS_PER_SEC) ?
					`TGS_NS_PER_SEC - 32'h1 : avm_in.writedata;
				`TGS_OFF_BASE_SLO: st_d.adm.base.sec[31:0] = avm_in.writedata;
				`TGS_OFF_BASE_SHI: st_d.adm.base.sec[47:32] = avm_in.writedata[15:0];
				`TGS_OFF_BASE_NS: st_d.adm.base.ns = avm_in.writedata;
				`TGS_OFF_ENT_IVL: st_d.ivl_stage = avm_in.writedata;
				`TGS_OFF_ENT_CTRL: begin
					st_d.gate_list[avm_in.writedata[2:0]].gates = avm_in.writedata[15:8];
					st_d.gate_list[avm_in.writedata[2:0]].hold_gate_operation = avm_in.writedata[16];
					st_d.gate_list[avm_in.writedata[2:0]].ivl = st_q.ivl_stage;
				end
				`TGS_OFF_LIST_LEN: st_d.adm.len = (avm_in.writedata[3:0] > `TGS_LIST_DEPTH) ?
					`TGS_LIST_DEPTH : avm_in.writedata[3:0];
				`TGS_OFF_TIMEOUT: st_d.timeout = avm_in.writedata[15:0];
				`TGS_OFF_COMMIT: begin
					if (avm_in.writedata[0]) begin
						if (st_q.oper_en && !t_ge(st_q.adm.base, st_q.now)) begin
							st_d.err = st_q.err + 32'h1;
						end
						st_d.defer_cnt = 16'h0;
						st_d.state = st_q.defer_en ? tgs_pkg::TGS_SYNC : tgs_pkg::TGS_ARM;
						st_d.chg = chg_time(st_q.adm.base, st_q.now);
					end
				end
				default: begin
					if (is_arr(avm_in.address, `TGS_OFF_SDU_BASE)) begin
						st_d.sdu[avm_in.address[4:2]] = (avm_in.writedata > {18'h0, `TGS_SDU_MAX}) ?
							`TGS_SDU_MAX : avm_in.writedata[13:0];
					end
				end
			endcase
		end
		if (bus_acc && avm_in.read) begin
			pb = st_q.oper.base;
			unique case (avm_in.address)
				`TGS_OFF_CTRL: rd = {14'h0, st_q.frag, st_q.pmask, st_q.sync_sense_port, 1'b0,
					st_q.defer_en, st_q.preempt_en, st_q.adm_en};
				`TGS_OFF_CYC_VAL: rd = st_q.adm.val;
				`TGS_OFF_CYC_UNIT: rd = {30'h0, st_q.adm.unit};
				`TGS_OFF_CYC_EXT: rd = st_q.adm.ext;
				`TGS_OFF_BASE_SLO: rd = st_q.adm.base.sec[31:0];
				`TGS_OFF_BASE_SHI: rd = {16'h0, st_q.adm.base.sec[47:32]};
				`TGS_OFF_BASE_NS: rd = st_q.adm.base.ns;
				`TGS_OFF_ENT_IVL: rd = st_q.ivl_stage;
				`TGS_OFF_LIST_LEN: rd = {28'h0, st_q.adm.len};
				`TGS_OFF_TIMEOUT: rd = {16'h0, st_q.timeout};
				`TGS_OFF_STAT: rd = {12'h0, st_q.preempt, st_q.gates, 1'b0, st_q.hold,
					st_q.schedule_change_pending, st_q.oper_en};
				`TGS_OFF_ERR: rd = st_q.err;
				`TGS_OFF_CHG_SLO: rd = st_q.chg.sec[31:0];
				`TGS_OFF_CHG_SHI: rd = {16'h0, st_q.chg.sec[47:32]};
				`TGS_OFF_CHG_NS: rd = st_q.chg.ns;
				`TGS_OFF_TICK: rd = `TGS_TICK_TENTHS;
				`TGS_OFF_OPER_LEN: rd = {28'h0, st_q.oper.len};
				`TGS_OFF_OPER_VAL: rd = st_q.oper.val;
				`TGS_OFF_OPER_UNIT: rd = {30'h0, st_q.oper.unit};
				`TGS_OFF_OPER_EXT: rd = st_q.oper.ext;
				`TGS_OFF_OPER_BSLO: rd = pb.sec[31:0];
				`TGS_OFF_OPER_BSHI: rd = {16'h0, pb.sec[47:32]};
				`TGS_OFF_OPER_BNS: rd = pb.ns;
				`TGS_OFF_NOW_SLO: rd = st_q.now.sec[31:0];
				`TGS_OFF_NOW_SHI: rd = {16'h0, st_q.now.sec[47:32]};
				`TGS_OFF_NOW_NS: rd = st_q.now.ns;
				default: begin
					if (is_arr(avm_in.address, `TGS_OFF_SDU_BASE)) begin
						rd = {18'h0, st_q.sdu[avm_in.address[4:2]]};
					end else if (is_arr(avm_in.address, `TGS_OFF_GUARD_BASE)) begin
						rd = {8'h0, st_q.guard[avm_in.address[4:2]]};
					end
				end
			endcase
			st_d.rsp.readdata = rd;
		end

		// Derived status and per-queue gates, preemption and guard bands
		st_d.schedule_change_pending = (st_d.state != tgs_pkg::TGS_IDLE);
		st_d.gates = st_d.oper_en ? st_d.gate_list[st_d.ent].gates : `TGS_GATES_OPEN;
		st_d.hold = st_d.oper_en & st_d.gate_list[st_d.ent].hold_gate_operation;
		for (int q = 0; q < 8; q++) begin
			st_d.preempt[q] = st_d.preempt_en & st_d.pmask[q] & ~(st_d.hold & st_d.gates[q]);
			if (st_d.preempt_en && st_d.hold && st_d.pmask[q]) begin
				gb = 14'(({12'h0, st_d.frag} + 14'h1) * `TGS_FRAG_UNIT) + `TGS_FRAG_EXTRA;
			end else begin
				gb = sdu_eff(st_d.sdu[q]);
			end
			st_d.guard[q] = guard_ns(gb, link_speed_in);
		end

		if (sys_rst_in) begin
			st_d = '0;
			st_d.rsp.waitrequest = 1'b1;
			st_d.state = tgs_pkg::TGS_IDLE;
			st_d.gates = `TGS_GATES_OPEN;
			for (int q = 0; q < 8; q++) begin
				st_d.sdu[q] = `TGS_SDU_RST;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		st_q <= st_d;
	end

	assign avm_out = st_q.rsp;
	assign oper_enabled_out = st_q.oper_en;
	assign gate_states_out = st_q.gates;
	assign hold_active_out = st_q.hold;
	assign preemptible_out = st_q.preempt;
	assign schedule_change_pending_out = st_q.schedule_change_pending;

	////////////////////////////////////////////////////////////////
	// Checks
	AST_SDU_CLAMP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_acc && is_arr(avm_in.address, `TGS_OFF_SDU_BASE) |=> st_q.sdu[$past(avm_in.address[4:2])] <= `TGS_SDU_MAX)
		else $error("max frame size above limit");
	AST_SDU_RESET: assert property (@(posedge clk_in)
		sys_rst_in |=> st_q.sdu[0] == `TGS_SDU_RST && st_q.sdu[7] == `TGS_SDU_RST)
		else $error("max frame size reset value wrong");
	AST_ZERO_MEANS_MAX: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.sdu[0] == 14'h0 && !st_q.preempt_en && $stable(link_speed_in) && $stable(st_q.sdu[0])
		|-> st_q.guard[0] == guard_ns(`TGS_SDU_MAX, link_speed_in))
		else $error("zero max frame size not taken as MAC maximum");
	AST_GUARD_1G: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		link_speed_in == `TGS_SPD_1G ##1 link_speed_in == `TGS_SPD_1G && !st_q.preempt_en && $stable(st_q.sdu[3])
		|-> st_q.guard[3] == 24'(sdu_eff(st_q.sdu[3]) * `TGS_BITS_PER_BYTE))
		else $error("guard band at 1G wrong");
	AST_PREEMPT_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!st_q.preempt_en [*2] |-> preemptible_out == 8'h00)
		else $error("queue preemptible with preemption off");
	AST_GATES_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!oper_enabled_out |-> gate_states_out == `TGS_GATES_OPEN && !hold_active_out)
		else $error("gates not open while schedule inactive");
	AST_COMMIT_PENDS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_acc && avm_in.address == `TGS_OFF_COMMIT && avm_in.writedata[0] |=> schedule_change_pending_out)
		else $error("pending flag not raised on change");
	AST_ERR_COUNT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_acc && avm_in.address == `TGS_OFF_COMMIT && avm_in.writedata[0] && st_q.oper_en &&
		!t_ge(st_q.adm.base, st_q.now) |=> st_q.err == $past(st_q.err) + 32'h1)
		else $error("past base change not counted");
	AST_DEFER_TIMEOUT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.state == tgs_pkg::TGS_SYNC && st_q.defer_cnt >= st_q.timeout && !wr_acc
		|=> st_q.state == tgs_pkg::TGS_ARM)
		else $error("deferred switch not released on timeout");
	AST_DEFER_LOCK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.state == tgs_pkg::TGS_SYNC && !locked && st_q.defer_cnt < st_q.timeout && !wr_acc
		|=> st_q.state == tgs_pkg::TGS_SYNC)
		else $error("deferred switch left early");
	AST_WAIT_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!avm_out.waitrequest |=> avm_out.waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_INSTALL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.state == tgs_pkg::TGS_ARM && t_ge(st_q.now, st_q.chg) && !wr_acc
		|=> oper_enabled_out == $past(st_q.adm_en) && !schedule_change_pending_out &&
			st_q.oper.len == $past(st_q.adm.len))
		else $error("schedule not installed at change time");
	AST_NOW_TRACKS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		1'b1 |=> st_q.now.sec == $past(ptp_sec_in) && st_q.now.ns == $past(ptp_ns_in))
		else $error("current time does not follow time base");
	// Guards lag their inputs by a cycle, hence the stable speed
	AST_HOLD_GUARD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.preempt_en && st_q.hold && st_q.pmask[2] && link_speed_in == `TGS_SPD_1G && $stable(link_speed_in)
		|-> st_q.guard[2] ==
			24'((({12'h0, st_q.frag} + 14'h1) * `TGS_FRAG_UNIT + `TGS_FRAG_EXTRA) * `TGS_BITS_PER_BYTE))
		else $error("hold guard band not fragment size plus 64");
	AST_STAT_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		bus_acc && avm_in.read && avm_in.address == `TGS_OFF_STAT
		|=> avm_out.readdata[11:4] == $past(gate_states_out) && avm_out.readdata[0] == $past(oper_enabled_out))
		else $error("status read does not show gate states");
	AST_SYNC_PORT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.state == tgs_pkg::TGS_SYNC && ptp_locked_in[st_q.sync_sense_port] && !wr_acc
		|=> st_q.state == tgs_pkg::TGS_ARM)
		else $error("selected lock bit did not release change");
	AST_PREEMPT_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		hold_active_out |-> (preemptible_out & gate_states_out) == 8'h00)
		else $error("queue opened by hold op marked preemptible");
	AST_ERR_STEP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.err != $past(st_q.err) |-> st_q.err == $past(st_q.err) + 32'h1)
		else $error("error counter moved by other than one");
	AST_CHG_FUTURE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_acc && avm_in.address == `TGS_OFF_COMMIT && avm_in.writedata[0] && t_ge(st_q.adm.base, st_q.now)
		|=> st_q.chg == $past(st_q.adm.base))
		else $error("change time differs from future base");
	COV_INSTALL: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(oper_enabled_out));
	COV_ERR: cover property (@(posedge clk_in) disable iff (sys_rst_in) st_q.err != $past(st_q.err));
	COV_TIMEOUT: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		st_q.state == tgs_pkg::TGS_SYNC && !locked ##1 st_q.state == tgs_pkg::TGS_ARM);
	COV_HOLD: cover property (@(posedge clk_in) disable iff (sys_rst_in) hold_active_out && preemptible_out != 8'h00);
	COV_STRETCH: cover property (@(posedge clk_in) disable iff (sys_rst_in) st_q.oper_en && st_q.state == tgs_pkg::TGS_ARM &&
		st_q.cyc_el + `TGS_CLK_NS >= st_q.oper_cyc_ns ##1 $stable(st_q.cyc_el));
endmodule

// [tb/tgs_ptp_model.sv]
`include "tgs_consts.svh"
module tgs_ptp_model (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [31:0] step_in,
	output logic [47:0] ptp_sec_out,
	output logic [31:0] ptp_ns_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [32:0] sum;
	assign sum = {1'b0, ptp_ns_out} + {1'b0, step_in};
	////////////////////////////////////////////////////////////
	// Step of zero freezes time so register reads are exact
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ptp_sec_out <= 48'h000000000005;
			ptp_ns_out <= 32'h00000000;
		end else if (sum >= {1'b0, `TGS_NS_PER_SEC}) begin
			ptp_sec_out <= ptp_sec_out + 48'h000000000001;
			ptp_ns_out <= 32'(sum - {1'b0, `TGS_NS_PER_SEC});
		end else begin
			ptp_ns_out <= sum[31:0];
		end
	end
endmodule

// [tb/tgs_scheduler_test.sv]
`include "tgs_consts.svh"
module tgs_scheduler_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	tgs_pkg::tgs_avm_req_t avm = '0;
	tgs_pkg::tgs_avm_rsp_t rsp;
	logic [15:0] locked = 16'h0000;
	logic [1:0] speed = 2'h2;
	logic [31:0] step = 32'h00000028;
	logic [47:0] psec;
	logic [31:0] pns;
	logic oen;
	logic [7:0] gates;
	logic hold;
	logic [7:0] pre;
	logic pend;
	int bad_count = 0;
	int n_checks = 0;
	logic [13:0] sdu [8];
	logic [47:0] bsec;
	logic [31:0] bns;
	int a;
	int b;
	always #20 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////
	tgs_scheduler dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avm_in(avm), .avm_out(rsp),
		.ptp_sec_in(psec), .ptp_ns_in(pns), .ptp_locked_in(locked), .link_speed_in(speed),
		.oper_enabled_out(oen), .gate_states_out(gates), .hold_active_out(hold),
		.preemptible_out(pre), .schedule_change_pending_out(pend));
	tgs_ptp_model ptp_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .step_in(step),
		.ptp_sec_out(psec), .ptp_ns_out(pns));
	////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		avm <= '{read: ~w, write: w, address: ad, writedata: d};
		do begin
			@(posedge clk_in);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 50);
		q = rsp.readdata;
		avm <= '0;
		if (n >= 50) begin
			bad_count++;
			tally_and_finish();
		end
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, ad, 32'h00000000, q);
		chk_reg(q, e);
	endtask
	task automatic set_base(input logic [47:0] s, input logic [31:0] n);
		wr(`TGS_OFF_BASE_SLO, s[31:0]);
		wr(`TGS_OFF_BASE_SHI, {16'h0000, s[47:32]});
		wr(`TGS_OFF_BASE_NS, n);
	endtask
	task automatic wait_pend(input logic v, input int lim);
		int n = 0;
		while (pend !== v && n < lim) begin
			@(posedge clk_in);
			n++;
		end
		if (pend !== v) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	task automatic wait_gates(input logic [7:0] g, output int n);
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (gates !== g && n < 2000);
		if (n >= 2000) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] gb(input logic [13:0] s, input logic [1:0] sp);
		logic [31:0] v;
		v = (s == 14'h0000) ? 32'h00002800 : {18'h00000, s};
		case (sp)
			2'h0: gb = v * 32'h00000320;
			2'h1: gb = v * 32'h00000050;
			2'h2: gb = v * 32'h00000008;
			default: gb = v * 32'h00000008 / 32'h0000000A;
		endcase
	endfunction
	////////////////////////////////////////////////////////////
	initial begin
		a = $urandom(32'h7133);
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		chk_pin({7'h00, oen}, 8'h00);
		chk_pin(gates, 8'hFF);
		chk_pin({7'h00, pend}, 8'h00);
		for (int q = 0; q < 8; q++) begin
			rd_chk(`TGS_OFF_SDU_BASE + 8'(4 * q), 32'h00000600);
			rd_chk(`TGS_OFF_GUARD_BASE + 8'(4 * q), 32'h00003000);
		end
		rd_chk(`TGS_OFF_TICK, 32'h00000190);
		rd_chk(8'hF0, 32'h00000000);
		// Corners first, then random sizes; 10241 must clamp
		for (int q = 0; q < 8; q++) begin
			a = (q == 0) ? 0 : (q == 1) ? 10240 : (q == 2) ? 10241 : $urandom_range(10240, 1);
			sdu[q] = (a > 10240) ? 14'h2800 : 14'(a);
			wr(`TGS_OFF_SDU_BASE + 8'(4 * q), 32'(a));
			rd_chk(`TGS_OFF_SDU_BASE + 8'(4 * q), {18'h00000, sdu[q]});
		end
		for (int s = 0; s < 4; s++) begin
			speed <= 2'(s);
			repeat (3) @(posedge clk_in);
			for (int q = 0; q < 8; q++) begin
				rd_chk(`TGS_OFF_GUARD_BASE + 8'(4 * q), gb(sdu[q], 2'(s)));
			end
		end
		speed <= 2'h2;
		for (int u = 0; u < 4; u++) begin
			wr(`TGS_OFF_CYC_UNIT, 32'(u));
			rd_chk(`TGS_OFF_CYC_UNIT, (u == 3) ? 32'h00000002 : 32'(u));
		end
		////////////////////////////////////////////////////////////
		step <= 32'h00000000;
		repeat (3) @(posedge clk_in);
		rd_chk(`TGS_OFF_NOW_SLO, psec[31:0]);
		rd_chk(`TGS_OFF_NOW_SHI, {16'h0000, psec[47:32]});
		rd_chk(`TGS_OFF_NOW_NS, pns);
		wr(`TGS_OFF_ENT_IVL, 32'h000000C8);
		wr(`TGS_OFF_ENT_CTRL, 32'h00000F00);
		wr(`TGS_OFF_ENT_IVL, 32'h00009C40);
		wr(`TGS_OFF_ENT_CTRL, 32'h0001F001);
		wr(`TGS_OFF_LIST_LEN, 32'h00000002);
		wr(`TGS_OFF_CYC_VAL, 32'h00000028);
		wr(`TGS_OFF_CYC_UNIT, 32'h00000001);
		wr(`TGS_OFF_CYC_EXT, 32'hFFFFFFFF);
		rd_chk(`TGS_OFF_CYC_EXT, 32'h3B9AC9FF);
		wr(`TGS_OFF_CTRL, 32'h00013C03);
		bsec = psec;
		bns = pns + 32'h00000FA0;
		set_base(bsec, bns);
		step <= 32'h00000028;
		wr(`TGS_OFF_COMMIT, 32'h00000001);
		chk_pin({7'h00, pend}, 8'h01);
		chk_pin({7'h00, oen}, 8'h00);
		wait_pend(1'b0, 500);
		@(posedge clk_in);
		chk_pin({7'h00, oen}, 8'h01);
		rd_chk(`TGS_OFF_CHG_SLO, bsec[31:0]);
		rd_chk(`TGS_OFF_CHG_NS, bns);
		rd_chk(`TGS_OFF_OPER_LEN, 32'h00000002);
		rd_chk(`TGS_OFF_OPER_VAL, 32'h00000028);
		rd_chk(`TGS_OFF_OPER_UNIT, 32'h00000001);
		rd_chk(`TGS_OFF_OPER_BNS, bns);
		rd_chk(`TGS_OFF_OPER_EXT, 32'h3B9AC9FF);
		wait_gates(8'h0F, a);
		@(posedge clk_in);
		chk_pin({7'h00, hold}, 8'h00);
		chk_pin(pre, 8'h3C);
		wait_gates(8'hF0, a);
		@(posedge clk_in);
		chk_pin({7'h00, hold}, 8'h01);
		chk_pin(pre, 8'h0C);
		// Queues 2..5 preemptable: 128-byte fragment plus 64 at 8 ns a byte
		for (int q = 0; q < 8; q++) begin
			rd_chk(`TGS_OFF_GUARD_BASE + 8'(4 * q), (q > 1 && q < 6) ? 32'h00000600 : gb(sdu[q], 2'h2));
		end
		rd_chk(`TGS_OFF_STAT, 32'h0000CF05);
		wait_gates(8'h0F, a);
		wait_gates(8'hF0, a);
		wait_gates(8'h0F, b);
		chk_reg(32'(a + b), 32'h000003E8);
		////////////////////////////////////////////////////////////
		step <= 32'h00000000;
		repeat (2) @(posedge clk_in);
		set_base(48'h000000000001, 32'h00000007);
		wr(`TGS_OFF_COMMIT, 32'h00000001);
		rd_chk(`TGS_OFF_ERR, 32'h00000001);
		rd_chk(`TGS_OFF_CHG_SLO, psec[31:0] + 32'h00000001);
		rd_chk(`TGS_OFF_CHG_NS, 32'h00000007);
		// Switch within the extension: last entry must stretch, not wrap
		wait_gates(8'hF0, b);
		a = 0;
		repeat (1001) begin
			@(posedge clk_in);
			a += (gates !== 8'hF0) ? 1 : 0;
		end
		chk_reg(32'(a), 32'h00000000);
		step <= 32'h10000000;
		wait_pend(1'b0, 100);
		// Deferred change: wrong lock bit must not release it
		step <= 32'h00000000;
		repeat (2) @(posedge clk_in);
		wr(`TGS_OFF_CTRL, 32'h00013C37);
		wr(`TGS_OFF_TIMEOUT, 32'h00000002);
		wr(`TGS_OFF_LIST_LEN, 32'h00000003);
		set_base(psec, pns);
		locked <= 16'h0004;
		wr(`TGS_OFF_COMMIT, 32'h00000001);
		repeat (40) @(posedge clk_in);
		chk_pin({7'h00, pend}, 8'h01);
		rd_chk(`TGS_OFF_OPER_LEN, 32'h00000002);
		locked <= 16'h0008;
		wait_pend(1'b0, 50);
		rd_chk(`TGS_OFF_OPER_LEN, 32'h00000003);
		rd_chk(`TGS_OFF_ERR, 32'h00000001);
		locked <= 16'h0000;
		wr(`TGS_OFF_LIST_LEN, 32'h00000002);
		set_base(psec, pns);
		wr(`TGS_OFF_COMMIT, 32'h00000001);
		chk_pin({7'h00, pend}, 8'h01);
		step <= 32'h20000000;
		wait_pend(1'b0, 200);
		rd_chk(`TGS_OFF_OPER_LEN, 32'h00000002);
		tally_and_finish();
	end
endmodule
